// ==== rtl/mbw_handler.sv ====
// Purpose: Slave handler for write register, loopback diagnostic, force coils
// Assumes: Frames arrive as bytes without error check field, end flagged
// Notes:   One request at a time; receive closed while busy
`timescale 1ns/10ps
`default_nettype none
`include "mbw_cfg.svh"
module mbw_handler
   import mbw_pkg::*;
(
   input  wire logic                        core_clk_i,   // System clock
   input  wire logic                        rst_b_i,      // Async reset, active low
   input  wire logic                        ce_i,         // Clock enable
   input  wire logic [7:0]                  own_addr_i,   // This slave's address
   input  wire logic [7:0]                  rx_byte_i,    // Request byte
   input  wire logic                        rx_valid_i,   // Request byte strobe
   input  wire logic                        rx_end_i,     // Frame end strobe
   input  wire logic                        rx_err_i,     // Frame had comm error
   output logic                             rx_ready_o,   // Ready for a frame
   output logic [7:0]                       tx_byte_o,    // Response byte
   output logic                             tx_valid_o,   // Response byte valid
   output logic                             tx_last_o,    // Last response byte
   input  wire logic                        tx_ready_i,   // Response byte taken
   output logic                             hreg_we_o,    // Holding register write
   output logic [15:0]                      hreg_addr_o,  // Holding register address
   output logic [15:0]                      hreg_val_o,   // Holding register value
   output logic [`MBW_NUM_COILS-1:0]        coils_o       // Coil image
);

   mbw_main_s q;
   mbw_main_s d;

   mbw_coil_if cw ();

   mbw_coil_bank u_bank (
      .core_clk_i (core_clk_i),
      .ce_i       (ce_i),
      .cw         (cw.bank)
   );

   // ***********************************************************************
   // Next-state logic
   // ***********************************************************************
   always_comb begin
      logic [7:0]  sa;
      logic [7:0]  fc;
      logic [15:0] w2;
      logic [15:0] w4;
      logic [16:0] ceil8;
      logic [16:0] top;
      logic        mine;
      logic        bc_ok;
      logic        exc;
      logic [7:0]  ecode;
      logic [3:0]  bi;
      sa    = q.buf_b[0];
      fc    = q.buf_b[1];
      w2    = {q.buf_b[2], q.buf_b[3]};
      w4    = {q.buf_b[4], q.buf_b[5]};
      ceil8 = ({1'b0, w4} + 17'h00007) >> 3;
      top   = {1'b0, w2} + {1'b0, w4};
      mine  = (sa == own_addr_i) || (sa == `MBW_BCAST_ADDR);
      exc   = 1'b0;
      ecode = `MBW_EXC_ILL_FN;
      bi    = `MBW_IX_DATA + {1'b0, q.k[5:3]};
      bc_ok = (fc == `MBW_FC_FORCE1) || (fc == `MBW_FC_WR_REG) ||
              (fc == `MBW_FC_FORCEN) || (fc == `MBW_FC_PRESETN) ||
              (fc == `MBW_FC_DIAG);
      d         = q;
      d.hreg_we = 1'b0;
      d.cw_we   = 1'b0;
      case (q.st)
         MBW_RX: begin
            if (rx_valid_i) begin
               if (q.len < `MBW_LEN_W'(`MBW_BUF_DEPTH)) begin
                  d.buf_b[q.len[3:0]] = rx_byte_i;
                  d.len               = q.len + 5'h01;
               end else begin
                  d.ovf = 1'b1;
               end
            end
            if (rx_end_i) begin
               if (rx_err_i || q.ovf || (q.len < 5'h02)) begin
                  d.len = 5'h00;
                  d.ovf = 1'b0;
               end else begin
                  d.st = MBW_EXEC;
               end
            end
         end
         MBW_EXEC: begin
            d.bcast = (sa == `MBW_BCAST_ADDR);
            d.rlen  = q.len;
            d.ti    = 5'h00;
            d.st    = MBW_SEND;
            case (fc)
               `MBW_FC_WR_REG: begin
                  if (q.len != `MBW_LEN_WR_REG) begin
                     exc   = 1'b1;
                     ecode = `MBW_EXC_ILL_VAL;
                  end else if (mine) begin
                     // Foreign frames never reach the register port
                     d.hreg_we   = 1'b1;
                     d.hreg_addr = w2;
                     d.hreg_val  = w4;
                  end
               end
               `MBW_FC_DIAG: begin
                  if (q.len < `MBW_LEN_DIAG) begin
                     exc   = 1'b1;
                     ecode = `MBW_EXC_ILL_VAL;
                  end else if (w2 != `MBW_SUB_ECHO) begin
                     exc = 1'b1;
                  end
               end
               `MBW_FC_FORCEN: begin
                  if ((w4 == 16'h0000) || (ceil8 != {9'h000, q.buf_b[6]}) ||
                      ({4'h0, q.len} != ({1'b0, q.buf_b[6]} + 9'h007))) begin
                     exc   = 1'b1;
                     ecode = `MBW_EXC_ILL_VAL;
                  end else if (top > 17'(`MBW_NUM_COILS)) begin
                     exc   = 1'b1;
                     ecode = `MBW_EXC_ILL_ADR;
                  end else begin
                     d.start = w2[`MBW_COIL_W-1:0];
                     d.qty   = w4[6:0];
                     d.k     = 7'h00;
                     d.st    = MBW_COIL;
                  end
               end
               default: begin
                  exc = 1'b1;
               end
            endcase
            if (exc) begin
               d.buf_b[1] = fc | `MBW_EXC_FLAG;
               d.buf_b[2] = ecode;
               d.rlen     = `MBW_LEN_EXC;
            end
            if (!mine || (d.bcast && (exc || !bc_ok))) begin
               d.st  = MBW_RX;
               d.len = 5'h00;
            end
         end
         MBW_COIL: begin
            d.cw_we  = 1'b1;
            d.cw_idx = q.start + q.k[`MBW_COIL_W-1:0];
            d.cw_val = q.buf_b[bi][q.k[2:0]];
            d.k      = q.k + 7'h01;
            if (d.k == q.qty) begin
               d.rlen = `MBW_LEN_WR_REG;
               d.st   = MBW_SEND;
            end
         end
         MBW_SEND: begin
            if (q.bcast) begin
               d.st  = MBW_RX;
               d.len = 5'h00;
            end else if (!q.tx_valid) begin
               d.tx_byte  = q.buf_b[q.ti[3:0]];
               d.tx_valid = 1'b1;
               d.tx_last  = (q.ti == q.rlen - 5'h01);
            end else if (tx_ready_i) begin
               d.tx_valid = 1'b0;
               d.tx_last  = 1'b0;
               d.ti       = q.ti + 5'h01;
               if (q.tx_last) begin
                  d.st  = MBW_RX;
                  d.len = 5'h00;
               end
            end
         end
         default: begin
            d.st  = MBW_RX;
            d.len = 5'h00;
         end
      endcase
   end

   // ***********************************************************************
   // State register
   // ***********************************************************************
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   // Coil bank sees registered write only; diagnostics never drive it
   assign cw.we  = q.cw_we;
   assign cw.idx = q.cw_idx;
   assign cw.val = q.cw_val;

   assign rx_ready_o  = (q.st == MBW_RX);
   assign tx_byte_o   = q.tx_byte;
   assign tx_valid_o  = q.tx_valid;
   assign tx_last_o   = q.tx_last;
   assign hreg_we_o   = q.hreg_we;
   assign hreg_addr_o = q.hreg_addr;
   assign hreg_val_o  = q.hreg_val;
   assign coils_o     = cw.coils;

endmodule
`default_nettype wire

// ==== rtl/mbw_cfg.svh ====
// Purpose: Constants of the fieldbus write and diagnostics request handler
// Assumes: Framing layer strips the error check field before this block
// Notes:   Widths, counts and codes for all design files
//
// Contract
// - Function 06 overwrites the addressed holding register with the two-byte value.
// - Register write to slave address zero loads the register in every slave.
// - Broadcast valid only for 5, 6, 15, 16 and loopback; others ignored.
// - Function 06 answer echoes the request unchanged after the write.
// - Function 08 test type from two-byte sub-function; response echoes both codes.
// - Diagnostics touch no coil, bit or register storage.
// - Only diagnostic sub-function zero supported; others are unsupported.
// - Sub-function zero returns a response identical to the request.
// - Function 15 forces each coil of a consecutive block to its state.
// - Coil addresses are zero based.
// - Function 15 coil states packed one bit per coil, one means on.
// - Lowest coil is LSB of first data byte, ascending bits then bytes.
// - Function 15 to address zero applies the coils in every slave.
// - Function 15 answer holds only address, function, start and quantity.
// - Function 15 writes coils whether or not they are disabled.
// - Local scan logic may change holding registers; master value may not persist.
// - Coil states survive reset; coils are never cleared automatically.
// - Exception answer sets function code MSB and adds one exception byte.
// - Unallowed function or sub-function gives exception code 01.
// - Request with a communication error gets no response.
`ifndef MBW_CFG_SVH
`define MBW_CFG_SVH

`define MBW_BUF_DEPTH   16
`define MBW_LEN_W       5
`define MBW_NUM_COILS   64
`define MBW_COIL_W      6
`define MBW_BCAST_ADDR  8'h00
`define MBW_FC_FORCE1   8'h05
`define MBW_FC_WR_REG   8'h06
`define MBW_FC_DIAG     8'h08
`define MBW_FC_FORCEN   8'h0F
`define MBW_FC_PRESETN  8'h10
`define MBW_SUB_ECHO    16'h0000
`define MBW_EXC_FLAG    8'h80
`define MBW_EXC_ILL_FN  8'h01
`define MBW_EXC_ILL_ADR 8'h02
`define MBW_EXC_ILL_VAL 8'h03
`define MBW_LEN_WR_REG  5'h06
`define MBW_LEN_DIAG    5'h04
`define MBW_LEN_COIL_HD 5'h07
`define MBW_LEN_EXC     5'h03
`define MBW_IX_DATA     4'h7

`endif

// ==== rtl/mbw_pkg.sv ====
// Purpose: Types of the fieldbus write and diagnostics request handler
// Assumes: mbw_cfg.svh gives the widths
// Notes:   State enum and per-module state records
`default_nettype none
`include "mbw_cfg.svh"
package mbw_pkg;

   typedef logic [7:0] mbw_byte_t;

   typedef enum logic [1:0] {
      MBW_RX   = 2'h0,
      MBW_EXEC = 2'h1,
      MBW_COIL = 2'h3,
      MBW_SEND = 2'h2
   } mbw_state_e;

   typedef struct packed {
      mbw_state_e                            st;
      logic [`MBW_BUF_DEPTH-1:0][7:0]        buf_b;
      logic [`MBW_LEN_W-1:0]                 len;
      logic                                  ovf;
      logic [`MBW_LEN_W-1:0]                 rlen;
      logic [`MBW_LEN_W-1:0]                 ti;
      logic                                  bcast;
      logic [6:0]                            k;
      logic [6:0]                            qty;
      logic [`MBW_COIL_W-1:0]                start;
      logic                                  cw_we;
      logic [`MBW_COIL_W-1:0]                cw_idx;
      logic                                  cw_val;
      logic                                  hreg_we;
      logic [15:0]                           hreg_addr;
      logic [15:0]                           hreg_val;
      mbw_byte_t                             tx_byte;
      logic                                  tx_valid;
      logic                                  tx_last;
   } mbw_main_s;

   typedef struct packed {
      logic [`MBW_NUM_COILS-1:0] coil;
   } mbw_bank_s;

endpackage
`default_nettype wire

// ==== rtl/mbw_coil_if.sv ====
// Purpose: Coil write path between request handler and coil bank
// Assumes: One write per clock at most
// Notes:   Coil image returns to the handler
`timescale 1ns/10ps
`default_nettype none
`include "mbw_cfg.svh"
interface mbw_coil_if;
   logic                         we;
   logic [`MBW_COIL_W-1:0]       idx;
   logic                         val;
   logic [`MBW_NUM_COILS-1:0]    coils;

   modport ctl  (output we, idx, val, input coils);
   modport bank (input we, idx, val, output coils);
endinterface
`default_nettype wire

// ==== rtl/mbw_coil_bank.sv ====
// Purpose: Coil storage written one coil at a time
// Assumes: Writes come from the request handler only
// Notes:   No reset on the coil image, power-up contents undefined
`timescale 1ns/10ps
`default_nettype none
`include "mbw_cfg.svh"
module mbw_coil_bank
   import mbw_pkg::*;
(
   input  wire logic   core_clk_i,   // System clock
   input  wire logic   ce_i,         // Clock enable
   mbw_coil_if.bank    cw            // Coil write port
);

   mbw_bank_s                 q;
   mbw_bank_s                 d;
   logic [`MBW_NUM_COILS-1:0] hit;

   // ***********************************************************************
   // Per-coil write decode
   // ***********************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `MBW_NUM_COILS; gi++) begin : g_coil
         assign hit[gi] = cw.we && (cw.idx == `MBW_COIL_W'(gi));
      end
   endgenerate

   // Hit coil takes the written value, disabled or not
   always_comb begin
      d      = q;
      d.coil = (q.coil & ~hit) | ({`MBW_NUM_COILS{cw.val}} & hit);
   end

   // Image kept through reset
   always_ff @(posedge core_clk_i) begin
      if (ce_i) begin
         q <= d;
      end
   end

   assign cw.coils = q.coil;

endmodule
`default_nettype wire

// ==== dv/mbw_chk.sv ====
// Purpose: Port checks of the request handler
// Assumes: ce_i held high
// Notes:   Bound from the testbench
`timescale 1ns/10ps
`default_nettype none
module mbw_chk (
   input wire logic       core_clk_i, // Clock
   input wire logic       rst_b_i,    // Reset
   input wire logic [7:0] rx_byte_i,  // Req byte
   input wire logic       rx_valid_i, // Byte strobe
   input wire logic       rx_end_i,   // Frame end
   input wire logic       rx_err_i,   // Comm error
   input wire logic       rx_ready_o, // Idle
   input wire logic [7:0] tx_byte_o,  // Rsp byte
   input wire logic       tx_valid_o, // Rsp valid
   input wire logic       tx_last_o,  // Rsp last
   input wire logic       tx_ready_i, // Rsp taken
   input wire logic       hreg_we_o   // Reg write
);
   // ****************
   // Frame address
   // ****************
   logic       got_q;
   logic [7:0] adr_q;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         got_q <= 1'b0;
         adr_q <= 8'h00;
      end else if (rx_ready_o && rx_end_i) begin
         got_q <= 1'b0;
      end else if (rx_ready_o && rx_valid_i && !got_q) begin
         got_q <= 1'b1;
         adr_q <= rx_byte_i;
      end
   end
   // Bytes of the frame being received, saturating
   logic [4:0] nb_q;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nb_q <= 5'h00;
      end else if (rx_ready_o && rx_end_i) begin
         nb_q <= 5'h00;
      end else if (rx_ready_o && rx_valid_i && nb_q != 5'h1F) begin
         nb_q <= nb_q + 5'h01;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_end_busy; rx_ready_o && rx_end_i && !rx_err_i && nb_q >= 5'h02 && nb_q <= 5'h10
      |=> !rx_ready_o; endproperty
   a_end_busy: assert property (p_end_busy) else $error("idle after frame end");
   property p_drop; rx_ready_o && rx_end_i && rx_err_i |=> rx_ready_o; endproperty
   a_drop: assert property (p_drop) else $error("busy after bad frame");
   property p_err; rx_ready_o && rx_end_i && rx_err_i |=> !tx_valid_o [*8]; endproperty
   a_err: assert property (p_err) else $error("reply to bad frame");
   property p_bc; rx_ready_o && rx_end_i && got_q && adr_q == 8'h00 |=> !tx_valid_o [*8];
   endproperty
   a_bc: assert property (p_bc) else $error("reply to broadcast");
   property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o)
      && $stable(tx_last_o); endproperty
   a_hold: assert property (p_hold) else $error("reply byte not held");
   property p_gap; tx_valid_o && tx_ready_i |=> !tx_valid_o; endproperty
   a_gap: assert property (p_gap) else $error("no gap after byte");
   property p_last; tx_valid_o && tx_ready_i && tx_last_o |=> ##[0:1] rx_ready_o; endproperty
   a_last: assert property (p_last) else $error("not idle after reply");
   property p_we; hreg_we_o |-> !tx_valid_o && !rx_ready_o ##1 !hreg_we_o; endproperty
   a_we: assert property (p_we) else $error("bad register write pulse");
   property p_busy; tx_valid_o |-> !rx_ready_o; endproperty
   a_busy: assert property (p_busy) else $error("idle while replying");
   c_we: cover property (hreg_we_o);
   c_exc: cover property (tx_valid_o && tx_byte_o == 8'h88);
   c_bc: cover property (rx_end_i && got_q && adr_q == 8'h00);
endmodule
`default_nettype wire

// ==== dv/mbw_master_model.sv ====
// Purpose: Fieldbus master sending requests and taking replies
// Assumes: Frames built by the caller
// Notes:   slow makes the reply side stall
`timescale 1ns/10ps
`default_nettype none
module mbw_master_model (
   input  wire logic       core_clk_i, // Clock
   output logic [7:0]      rx_byte_o,  // Req byte
   output logic            rx_valid_o, // Byte strobe
   output logic            rx_end_o,   // Frame end
   output logic            rx_err_o,   // Comm error
   input  wire logic [7:0] tx_byte_i,  // Rsp byte
   input  wire logic       tx_valid_i, // Rsp valid
   output logic            tx_ready_o  // Rsp taken
);
   // ****************
   // Request and reply
   // ****************
   logic [7:0] rsp[$];
   logic       slow = 1'b0;
   logic [1:0] cnt = 2'h0;
   initial begin
      rx_byte_o = 8'h5A;
      rx_valid_o = 1'b0;
      rx_end_o = 1'b0;
      rx_err_o = 1'b0;
      tx_ready_o = 1'b1;
   end
   task automatic send(input logic [7:0] f[$], input logic err);
      foreach (f[i]) begin
         @(posedge core_clk_i);
         #1;
         rx_byte_o = f[i];
         rx_valid_o = 1'b1;
      end
      @(posedge core_clk_i);
      #1;
      rx_byte_o = ~rx_byte_o;
      rx_valid_o = 1'b0;
      rx_end_o = 1'b1;
      rx_err_o = err;
      @(posedge core_clk_i);
      #1;
      rx_end_o = 1'b0;
      rx_err_o = 1'b0;
   endtask
   always @(posedge core_clk_i) begin
      if (tx_valid_i && tx_ready_o) rsp.push_back(tx_byte_i);
      cnt <= cnt + 2'h1;
      tx_ready_o <= #1 !slow || cnt == 2'h2;
   end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the request handler
// Assumes: Slave address 11, clock enable high
// Notes:   Coils are written in full before compared
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic             core_clk_i = 1'b0;
   logic             rst_b_i = 1'b0;
   logic             ce_i = 1'b1;
   logic [7:0]       own_addr_i = 8'h11;
   wire logic [7:0]  rx_byte_i, tx_byte_o;
   wire logic        rx_valid_i, rx_end_i, rx_err_i, tx_ready_i;
   wire logic        rx_ready_o, tx_valid_o, tx_last_o, hreg_we_o;
   wire logic [15:0] hreg_addr_o, hreg_val_o;
   wire logic [63:0] coils_o;
   int               n_fail = 0, check_count = 0, cyc = 0, we_n = 0;
   logic [15:0]      we_a, we_v;
   logic [7:0]       e[$];
   mbw_handler mbw_handler_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
      .own_addr_i(own_addr_i), .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i),
      .rx_end_i(rx_end_i), .rx_err_i(rx_err_i), .rx_ready_o(rx_ready_o),
      .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
      .tx_ready_i(tx_ready_i), .hreg_we_o(hreg_we_o), .hreg_addr_o(hreg_addr_o),
      .hreg_val_o(hreg_val_o), .coils_o(coils_o));
   mbw_master_model m_inst (.core_clk_i(core_clk_i), .rx_byte_o(rx_byte_i),
      .rx_valid_o(rx_valid_i), .rx_end_o(rx_end_i), .rx_err_o(rx_err_i),
      .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
   // ****************
   // Clock and helpers
   // ****************
   always #10 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cyc++;
      if (hreg_we_o === 1'b1) begin
         we_n++;
         we_a = hreg_addr_o;
         we_v = hreg_val_o;
      end
      if (cyc == 5000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
      check_count++;
      if (g !== x) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic xfer(input logic [7:0] f[$], input logic err, input logic [7:0] x[$],
                       input int we);
      int n;
      n = we_n;
      m_inst.rsp.delete();
      m_inst.send(f, err);
      for (int t = 0; t < 300 && rx_ready_o !== 1'b1; t++) begin
         @(posedge core_clk_i);
         #1;
      end
      chk("idle", 64'h1, 64'(rx_ready_o));
      repeat (4) @(posedge core_clk_i);
      chk("rsp_len", 64'(x.size()), 64'(m_inst.rsp.size()));
      foreach (x[i]) chk("rsp_byte", 64'(x[i]), 64'(m_inst.rsp[i]));
      chk("wr_cnt", 64'(we), 64'(we_n - n));
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_wr_reg();
      logic [7:0] q[$] = '{8'h11, 8'h06, 8'h00, 8'h12, 8'hBE, 8'hEF};
      logic [7:0] b[$] = '{8'h00, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34};
      xfer(q, 1'b0, q, 1);
      chk("reg", 64'h0012BEEF, {32'h0, we_a, we_v});
      xfer(b, 1'b0, e, 1);
      chk("reg", 64'h00051234, {32'h0, we_a, we_v});
      xfer(q, 1'b1, e, 0);
      xfer(q[0:4], 1'b0, '{8'h11, 8'h86, 8'h03}, 0);
      q[0] = 8'h22;
      xfer(q, 1'b0, e, 0);
      chk("reg_hold", 64'h00051234, {32'h0, hreg_addr_o, hreg_val_o});
   endtask
   task automatic t_diag();
      logic [7:0]  q[$] = '{8'h11, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37};
      logic [7:0]  u[$] = '{8'h11, 8'h08, 8'h00, 8'h01, 8'hA5, 8'h37};
      logic [7:0]  r[$] = '{8'h11, 8'h03, 8'h00, 8'h6B, 8'h00, 8'h03};
      logic [63:0] x;
      x = coils_o;
      xfer(q, 1'b0, q, 0);
      chk("coils", x, coils_o);
      xfer(u, 1'b0, '{8'h11, 8'h88, 8'h01}, 0);
      xfer(r, 1'b0, '{8'h11, 8'h83, 8'h01}, 0);
      r[0] = 8'h00;
      xfer(r, 1'b0, e, 0);
   endtask
   task automatic t_coils();
      logic [7:0]  a[$] = '{8'h11, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h40, 8'h08, 8'hA5, 8'h5A,
                            8'hFF, 8'h00, 8'h3C, 8'hC3, 8'h0F, 8'hF0};
      logic [7:0]  q[$] = '{8'h11, 8'h0F, 8'h00, 8'h13, 8'h00, 8'h0A, 8'h02, 8'hCD, 8'h02};
      logic [7:0]  b[$] = '{8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h05};
      logic [7:0]  o[$] = '{8'h11, 8'h0F, 8'h00, 8'h3C, 8'h00, 8'h08, 8'h01, 8'hFF};
      logic [15:0] d = 16'h02CD;
      logic [63:0] x = 64'hF00FC33C00FF5AA5;
      xfer(a, 1'b0, a[0:5], 0);
      chk("coils", x, coils_o);
      for (int k = 0; k < 10; k++) x[19 + k] = d[k];
      m_inst.slow = 1'b1;
      xfer(q, 1'b0, q[0:5], 0);
      m_inst.slow = 1'b0;
      chk("coils", x, coils_o);
      xfer(o, 1'b0, '{8'h11, 8'h8F, 8'h02}, 0);
      chk("coils", x, coils_o);
      x[2:0] = 3'h5;
      xfer(b, 1'b0, e, 0);
      chk("coils", x, coils_o);
      @(posedge core_clk_i);
      #1;
      rst_b_i = 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1;
      rst_b_i = 1'b1;
      chk("coils", x, coils_o);
   endtask
   initial begin
      repeat (2) @(posedge core_clk_i);
      #1;
      rst_b_i = 1'b1;
      t_coils();
      t_wr_reg();
      t_diag();
      give_verdict();
   end
endmodule
bind mbw_handler mbw_chk mbw_chk_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
   .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .rx_end_i(rx_end_i),
   .rx_err_i(rx_err_i), .rx_ready_o(rx_ready_o), .tx_byte_o(tx_byte_o),
   .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
   .hreg_we_o(hreg_we_o));
`default_nettype wire
